/* bench/timer_prescaler_control_bench.sv */
// Purpose: Self-checking bench for the timer and prescaler control block
// Assumes: The control design file carries its own assertions and covers
// Notes:   Read data is checked by a monitor against a queue of notes
`timescale 1ns/1ns
`include "timer_prescaler_params.svh"
module timer_prescaler_control_bench;
    import timer_prescaler_pkg::*;

    logic        clock;
    logic        rstn;
    logic [7:0]  sfr_addr;
    byte_t       sfr_wdata;
    logic        sfr_write;
    logic        sfr_read;
    byte_t       sfr_rdata;
    byte_t       mode_wdata;
    logic        mode_write;
    byte_t       mode_rdata;
    count_t      timer1_count;
    count_t      timer2_count;
    count_t      timer3_count;
    logic        timer3_underflow;
    logic        ext_irq_two_event;
    logic        inst_clock_tick;
    logic        external_count_pin;
    logic        low_osc_clock;
    logic        watchdog_irq_mode;
    logic        watchdog_tick;
    logic [1:0]  timer1_reload_upper;
    logic [1:0]  timer2_reload_upper;
    logic [1:0]  timer3_reload_upper;
    logic [1:0]  pwm_one_duty_upper;
    logic [1:0]  pwm_two_duty_upper;
    logic [1:0]  pwm_three_duty_upper;
    logic        timer_three_underflow_flag;
    logic        ext_irq_two_flag;
    logic        timer_three_underflow_enable;
    logic        ext_irq_two_enable;
    logic        timer0_tick;
    logic        watchdog_prescaled_tick;
    logic [7:0]  prescaler_count;
    logic [1:0]  reload_strobe;
    logic [15:0] notes[$];
    logic [15:0] note;
    logic        rd_d = 1'b0;
    int          num_errors = 0;
    int          comparisons = 0;
    int          t0n = 0;
    int          wdn = 0;
    int          i;
    int          r;
    int          m;
    int          e;
    byte_t       d;

    timer_prescaler_control timer_prescaler_control_i (
        .clock, .rstn, .sfr_addr, .sfr_wdata, .sfr_write, .sfr_read,
        .sfr_rdata, .mode_wdata, .mode_write, .mode_rdata,
        .timer1_count, .timer2_count, .timer3_count, .timer3_underflow,
        .ext_irq_two_event, .inst_clock_tick, .external_count_pin,
        .low_osc_clock, .watchdog_irq_mode, .watchdog_tick,
        .timer1_reload_upper, .timer2_reload_upper, .timer3_reload_upper,
        .timer1_reload_write(reload_strobe), .pwm_one_duty_upper,
        .pwm_two_duty_upper, .pwm_three_duty_upper,
        .timer_three_underflow_flag,
        .ext_irq_two_flag, .timer_three_underflow_enable,
        .ext_irq_two_enable, .timer0_tick, .watchdog_prescaled_tick,
        .prescaler_count
    );

    // ****************************************
    // Clock, tick counters and read monitor
    // ****************************************
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock) begin
        rd_d <= sfr_read;
        if (timer0_tick === 1'b1) t0n++;
        if (watchdog_prescaled_tick === 1'b1) wdn++;
    end

    always @(negedge clock) begin
        if (rd_d === 1'b1) begin
            if (notes.size() == 0) chk("read note", 16'h0, 16'h1);
            else begin
                note = notes.pop_front();
                chk("sfr_rdata", note[7:0], {8'h00, sfr_rdata & note[15:8]});
            end
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic step(int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(logic [7:0] a, byte_t v);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_write = 1'b1;
        step(1);
        sfr_write = 1'b0;
        chk("strobe", {14'd0, a == `ADDR_TIMER3_UPPER,
            a == `ADDR_TIMER_UPPER}, {14'd0, reload_strobe});
        step(1);
    endtask

    task automatic rd(logic [7:0] a, byte_t exp, byte_t mask);
        sfr_addr = a;
        sfr_read = 1'b1;
        notes.push_back({mask, exp & mask});
        step(1);
        sfr_read = 1'b0;
        step(1);
    endtask

    task automatic mode(byte_t v);
        mode_wdata = v;
        mode_write = 1'b1;
        step(1);
        mode_write = 1'b0;
        step(4);
    endtask

    task automatic pulse_events;
        timer3_underflow = 1'b1;
        ext_irq_two_event = 1'b1;
        step(1);
        timer3_underflow = 1'b0;
        ext_irq_two_event = 1'b0;
        step(1);
    endtask

    task automatic summarize;
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        summarize;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        {rstn, sfr_addr, sfr_wdata, sfr_write, sfr_read} = '0;
        {mode_wdata, mode_write, timer1_count, timer2_count} = '0;
        {timer3_count, timer3_underflow, ext_irq_two_event} = '0;
        {inst_clock_tick, external_count_pin, low_osc_clock} = '0;
        {watchdog_irq_mode, watchdog_tick} = '0;
        void'($urandom(32'h7CC33480));
        step(3);
        rstn = 1'b1;
        step(1);
        chk("mode reset", 16'h3F, mode_rdata);
        chk("prescaler reset", 16'hFF, prescaler_count);
        for (i = 0; i < 4; i++) begin
            d = byte_t'($urandom);
            timer1_count = count_t'($urandom);
            timer2_count = count_t'($urandom);
            timer3_count = count_t'($urandom);
            wr(`ADDR_TIMER_UPPER, d);
            chk("timer2 reload", d[7:6], timer2_reload_upper);
            chk("timer1 reload", d[5:4], timer1_reload_upper);
            chk("pwm2 duty", d[3:2], pwm_two_duty_upper);
            chk("pwm1 duty", d[1:0], pwm_one_duty_upper);
            rd(`ADDR_TIMER_UPPER, {timer2_count[9:8], timer1_count[9:8],
                d[3:0]}, 8'hFF);
            wr(`ADDR_TIMER3_UPPER, d);
            chk("timer3 reload", d[5:4], timer3_reload_upper);
            chk("pwm3 duty", d[1:0], pwm_three_duty_upper);
            rd(`ADDR_TIMER3_UPPER, {2'b00, timer3_count[9:8], 2'b00,
                d[1:0]}, 8'h33);
        end
        wr(8'h1A, 8'hFF);
        rd(8'h1A, 8'h00, 8'hFF);
        chk("mode untouched", 16'h3F, mode_rdata);
        wr(`ADDR_IRQ2, 8'h00);
        pulse_events;
        step(5);
        chk("t3 flag", 1, timer_three_underflow_flag);
        chk("irq2 flag", 1, ext_irq_two_flag);
        rd(`ADDR_IRQ2, 8'h00, 8'h99);
        wr(`ADDR_IRQ2, 8'h99);
        chk("enables", 2'b11, {ext_irq_two_enable,
            timer_three_underflow_enable});
        rd(`ADDR_IRQ2, 8'h99, 8'h99);
        wr(`ADDR_IRQ2, 8'h09);
        rd(`ADDR_IRQ2, 8'h09, 8'h99);
        pulse_events;
        rd(`ADDR_IRQ2, 8'h99, 8'h99);
        sfr_addr = `ADDR_IRQ2;
        sfr_wdata = 8'h09;
        sfr_write = 1'b1;
        timer3_underflow = 1'b1;
        ext_irq_two_event = 1'b1;
        step(1);
        {sfr_write, timer3_underflow, ext_irq_two_event} = '0;
        step(1);
        rd(`ADDR_IRQ2, 8'h99, 8'h99);
        d = byte_t'($urandom);
        mode(d);
        chk("mode reg", d, mode_rdata);
        mode(d ^ 8'h40);
        chk("mode reg", d ^ 8'h40, mode_rdata);
        inst_clock_tick = 1'b1;
        for (r = 0; r < 8; r++) begin
            mode({1'b0, r[0], 3'b000, r[2:0]});
            t0n = 0;
            step(2 << (r + 1));
            chk("timer0 ticks", 16'd2, 16'(t0n));
        end
        inst_clock_tick = 1'b0;
        mode(8'h08);
        watchdog_tick = 1'b1;
        for (m = 0; m < 2; m++) begin
            for (r = 0; r < 8; r++) begin
                watchdog_irq_mode = m[0];
                mode({5'b00001, r[2:0]});
                wdn = 0;
                step(2 << (r + m));
                chk("wdt ticks", 16'd2, 16'(wdn));
            end
        end
        watchdog_tick = 1'b0;
        for (e = 0; e < 4; e++) begin
            mode({e[1], 2'b01, e[0], 4'b1000});
            t0n = 0;
            if (e[1]) low_osc_clock = 1'b1;
            else external_count_pin = 1'b1;
            step(6);
            chk("rise ticks", {15'd0, !e[0]}, 16'(t0n));
            low_osc_clock = 1'b0;
            external_count_pin = 1'b0;
            step(6);
            chk("edge ticks", 16'd1, 16'(t0n));
        end
        mode(8'h08);
        t0n = 0;
        external_count_pin = 1'b1;
        step(4);
        external_count_pin = 1'b0;
        step(4);
        chk("pin ignored", 16'd0, 16'(t0n));
        inst_clock_tick = 1'b1;
        step(3);
        inst_clock_tick = 1'b0;
        step(4);
        chk("inst ticks", 16'd3, 16'(t0n));
        summarize;
    end
endmodule

/* core/prescaler_divider.sv */
// Purpose: Shared eight-bit prescaler with selectable divide ratio
// Assumes: Count enable is one cycle per source tick
// Notes:   Tick out is one cycle wide
`timescale 1ns/1ns
`include "timer_prescaler_params.svh"
module prescaler_divider #(
    parameter int WIDTH = 8
) (
    input  wire logic                             clock,
    input  wire logic                             rstn,
    input  wire logic                             tick_in,
    input  wire timer_prescaler_pkg::rate_t       rate,
    input  wire logic                             pass_one,
    output logic [WIDTH-1:0]                      count,
    output logic                                  tick_out
);
    import timer_prescaler_pkg::*;

    if (WIDTH != 8) begin : width_check
        $error("prescaler width must be 8");
    end

    logic [WIDTH-1:0] mask;
    logic [WIDTH-1:0] next_count;

    // Ratio 2^(rate+1), or 2^rate when pass_one
    always_comb begin
        mask = pass_one ? WIDTH'((9'h001 << rate) - 9'h001)
                        : WIDTH'((9'h002 << rate) - 9'h001);
        next_count = count + WIDTH'(1);
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count <= `PRESCALE_RESET;
        end else if (tick_in) begin
            count <= next_count;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= tick_in && ((next_count & mask) == 8'h00);
        end
    end
endmodule

/* core/timer_prescaler_control.sv */
// Purpose: Timer0 clock select, shared prescaler and timer upper bits
// Assumes: Inputs synchronous to the instruction clock
// Notes:   Mode register reached only by its move instructions
// Notes on behaviour
// - Timer2 upper field writes reload, reads count
// - Timer1 upper field writes reload, reads count
// - Timer3 upper field writes reload, reads count
// - Shared byte holds PWM2 and PWM1 upper bits
// - Timer3 byte holds PWM3 upper bits
// - Timer3 underflow sets flag until firmware clears
// - External irq two sets flag, firmware clears
// - Bits 0 and 3 enable the two sources
// - Disabled source flag reads as zero
// - Mode register only via move instructions
// - Assignment bit picks watchdog or Timer0
// - Timer0 or watchdog irq: 1:2 to 1:256
// - Watchdog reset mode: 1:1 to 1:128
// - Edge bit one counts falling, zero rising
// - Edge bit also applies to low oscillator
// - Source bit picks instruction clock or external
// - Low clock bit substitutes low oscillator
// - Bit 6 is plain spare storage
`timescale 1ns/1ns
`include "timer_prescaler_params.svh"
module timer_prescaler_control #(
    parameter int PRESCALE_WIDTH = 8
) (
    input  wire logic                         clock,
    input  wire logic                         rstn,
    input  wire logic [7:0]                   sfr_addr,
    input  wire timer_prescaler_pkg::byte_t   sfr_wdata,
    input  wire logic                         sfr_write,
    input  wire logic                         sfr_read,
    output timer_prescaler_pkg::byte_t        sfr_rdata,
    input  wire timer_prescaler_pkg::byte_t   mode_wdata,
    input  wire logic                         mode_write,
    output timer_prescaler_pkg::byte_t        mode_rdata,
    input  wire timer_prescaler_pkg::count_t  timer1_count,
    input  wire timer_prescaler_pkg::count_t  timer2_count,
    input  wire timer_prescaler_pkg::count_t  timer3_count,
    input  wire logic                         timer3_underflow,
    input  wire logic                         ext_irq_two_event,
    input  wire logic                         inst_clock_tick,
    input  wire logic                         external_count_pin,
    input  wire logic                         low_osc_clock,
    input  wire logic                         watchdog_irq_mode,
    input  wire logic                         watchdog_tick,
    output logic [1:0]                        timer1_reload_upper,
    output logic [1:0]                        timer2_reload_upper,
    output logic [1:0]                        timer3_reload_upper,
    output logic [1:0]                        timer1_reload_write,
    output logic [1:0]                        pwm_one_duty_upper,
    output logic [1:0]                        pwm_two_duty_upper,
    output logic [1:0]                        pwm_three_duty_upper,
    output logic                              timer_three_underflow_flag,
    output logic                              ext_irq_two_flag,
    output logic                              timer_three_underflow_enable,
    output logic                              ext_irq_two_enable,
    output logic                              timer0_tick,
    output logic                              watchdog_prescaled_tick,
    output logic [PRESCALE_WIDTH-1:0]         prescaler_count
);
    import timer_prescaler_pkg::*;

    if (PRESCALE_WIDTH != 8) begin : width_check
        $error("prescaler width must be 8");
    end

    // ****************************************
    // Register writes
    // ****************************************
    logic wr_upper;
    logic wr_t3;
    logic wr_irq;
    byte_t mode;
    assign wr_upper = sfr_write && (sfr_addr == `ADDR_TIMER_UPPER);
    assign wr_t3    = sfr_write && (sfr_addr == `ADDR_TIMER3_UPPER);
    assign wr_irq   = sfr_write && (sfr_addr == `ADDR_IRQ2);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            timer1_reload_upper <= 2'h0;
            timer2_reload_upper <= 2'h0;
            pwm_one_duty_upper  <= 2'h0;
            pwm_two_duty_upper  <= 2'h0;
        end else if (wr_upper) begin
            timer2_reload_upper <= sfr_wdata[`BIT_T2_HI:`BIT_T2_LO];
            timer1_reload_upper <= sfr_wdata[`BIT_T1_HI:`BIT_T1_LO];
            pwm_two_duty_upper  <=
                sfr_wdata[`BIT_PWM2_HI:`BIT_PWM2_LO];
            pwm_one_duty_upper  <=
                sfr_wdata[`BIT_PWM1_HI:`BIT_PWM1_LO];
        end
    end

    // Reload strobes, one cycle, for the timers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            timer1_reload_write <= 2'h0;
        end else begin
            timer1_reload_write <= {wr_t3, wr_upper};
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            timer3_reload_upper  <= 2'h0;
            pwm_three_duty_upper <= 2'h0;
        end else if (wr_t3) begin
            timer3_reload_upper  <= sfr_wdata[`BIT_T3_HI:`BIT_T3_LO];
            pwm_three_duty_upper <=
                sfr_wdata[`BIT_PWM3_HI:`BIT_PWM3_LO];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            timer_three_underflow_enable <= 1'b0;
            ext_irq_two_enable           <= 1'b0;
        end else if (wr_irq) begin
            timer_three_underflow_enable <= sfr_wdata[`BIT_T3_EN];
            ext_irq_two_enable           <= sfr_wdata[`BIT_IRQ2_EN];
        end
    end

    // Set wins over a firmware clear in the same cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            timer_three_underflow_flag <= 1'b0;
        end else if (timer3_underflow) begin
            timer_three_underflow_flag <= 1'b1;
        end else if (wr_irq) begin
            timer_three_underflow_flag <= sfr_wdata[`BIT_T3_FLAG];
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ext_irq_two_flag <= 1'b0;
        end else if (ext_irq_two_event) begin
            ext_irq_two_flag <= 1'b1;
        end else if (wr_irq) begin
            ext_irq_two_flag <= sfr_wdata[`BIT_IRQ2_FLAG];
        end
    end

    // ****************************************
    // Register reads
    // ****************************************
    byte_t next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        case (sfr_addr)
            `ADDR_TIMER_UPPER: begin
                next_rdata[`BIT_T2_HI:`BIT_T2_LO] = timer2_count[9:8];
                next_rdata[`BIT_T1_HI:`BIT_T1_LO] = timer1_count[9:8];
                next_rdata[`BIT_PWM2_HI:`BIT_PWM2_LO] = pwm_two_duty_upper;
                next_rdata[`BIT_PWM1_HI:`BIT_PWM1_LO] = pwm_one_duty_upper;
            end
            `ADDR_TIMER3_UPPER: begin
                next_rdata[`BIT_T3_HI:`BIT_T3_LO] = timer3_count[9:8];
                next_rdata[`BIT_PWM3_HI:`BIT_PWM3_LO] = pwm_three_duty_upper;
            end
            `ADDR_IRQ2: begin
                next_rdata[`BIT_IRQ2_FLAG] =
                    ext_irq_two_flag & ext_irq_two_enable;
                next_rdata[`BIT_T3_FLAG] =
                    timer_three_underflow_flag
                    & timer_three_underflow_enable;
                next_rdata[`BIT_IRQ2_EN] = ext_irq_two_enable;
                next_rdata[`BIT_T3_EN]   = timer_three_underflow_enable;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sfr_rdata <= 8'h00;
        end else if (sfr_read) begin
            sfr_rdata <= next_rdata;
        end
    end

    // ****************************************
    // Timer0 mode register
    // ****************************************
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mode <= `MODE_RESET;
        end else if (mode_write) begin
            mode <= mode_wdata;
        end
    end
    assign mode_rdata = mode;

    // ****************************************
    // Timer0 clock source and edge
    // ****************************************
    logic ext_src;
    logic ext_prev;
    logic ext_edge;
    logic src_tick;
    logic to_wdt;
    logic pre_in;
    logic pre_out;

    assign ext_src = mode[`BIT_LOW_SUB] ? low_osc_clock : external_count_pin;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= ext_src;
        end
    end

    assign ext_edge = mode[`BIT_EDGE] ? (ext_prev && !ext_src)
                                      : (!ext_prev && ext_src);
    assign src_tick = mode[`BIT_SRC] ? ext_edge : inst_clock_tick;

    // ****************************************
    // Shared prescaler
    // ****************************************
    assign to_wdt = mode[`BIT_TO_WDT];
    assign pre_in = to_wdt ? watchdog_tick : src_tick;

    prescaler_divider #(
        .WIDTH   (PRESCALE_WIDTH)
    ) u_prescaler (
        .clock   (clock),
        .rstn    (rstn),
        .tick_in (pre_in),
        .rate    (mode[`RATE_HI:`RATE_LO]),
        .pass_one(to_wdt && !watchdog_irq_mode),
        .count   (prescaler_count),
        .tick_out(pre_out)
    );

    assign timer0_tick = to_wdt ? src_tick : pre_out;
    assign watchdog_prescaled_tick = to_wdt ? pre_out : watchdog_tick;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    t3_flag_set_a: assert property (timer3_underflow |=>
        timer_three_underflow_flag) else $error("t3 flag not set");
    irq2_flag_set_a: assert property (ext_irq_two_event |=>
        ext_irq_two_flag) else $error("irq2 flag not set");
    flag_hold_a: assert property (timer_three_underflow_flag
        && !wr_irq |=> timer_three_underflow_flag)
        else $error("t3 flag dropped");
    mask_read_a: assert property (sfr_read && sfr_addr == `ADDR_IRQ2
        && !timer_three_underflow_enable |=> !sfr_rdata[`BIT_T3_FLAG])
        else $error("masked flag read");
    t2_read_a: assert property (sfr_read
        && sfr_addr == `ADDR_TIMER_UPPER
        |=> sfr_rdata[`BIT_T2_HI:`BIT_T2_LO] == $past(timer2_count[9:8]))
        else $error("t2 count read");
    t1_read_a: assert property (sfr_read
        && sfr_addr == `ADDR_TIMER_UPPER
        |=> sfr_rdata[`BIT_T1_HI:`BIT_T1_LO] == $past(timer1_count[9:8]))
        else $error("t1 count read");
    t3_read_a: assert property (sfr_read
        && sfr_addr == `ADDR_TIMER3_UPPER
        |=> sfr_rdata[`BIT_T3_HI:`BIT_T3_LO] == $past(timer3_count[9:8]))
        else $error("t3 count read");
    t1_write_a: assert property (wr_upper |=> timer1_reload_upper ==
        $past(sfr_wdata[`BIT_T1_HI:`BIT_T1_LO])) else $error("t1 write");
    pwm_write_a: assert property (wr_upper |=>
        {pwm_two_duty_upper, pwm_one_duty_upper}
        == $past(sfr_wdata[`BIT_PWM2_HI:`BIT_PWM1_LO]))
        else $error("pwm upper write");
    pwm3_write_a: assert property (wr_t3 |=> pwm_three_duty_upper ==
        $past(sfr_wdata[`BIT_PWM3_HI:`BIT_PWM3_LO]))
        else $error("pwm3 write");
    enable_write_a: assert property (wr_irq |=>
        timer_three_underflow_enable == $past(sfr_wdata[`BIT_T3_EN])
        && ext_irq_two_enable == $past(sfr_wdata[`BIT_IRQ2_EN]))
        else $error("enable write");
    irq2_hold_a: assert property (ext_irq_two_flag && !wr_irq
        |=> ext_irq_two_flag) else $error("irq2 flag dropped");
    irq2_mask_a: assert property (sfr_read && sfr_addr == `ADDR_IRQ2
        && !ext_irq_two_enable |=> !sfr_rdata[`BIT_IRQ2_FLAG])
        else $error("masked irq2 read");
    mode_only_a: assert property (!mode_write |=> $stable(mode))
        else $error("mode changed");
    reset_pass_a: assert property (to_wdt && !watchdog_irq_mode
        && mode[`RATE_HI:`RATE_LO] == 3'h0 && watchdog_tick |=> pre_out)
        else $error("rate one missed");
    timer_gap_a: assert property (!to_wdt && $stable(mode) && pre_out
        |=> !pre_out) else $error("timer0 ratio below two");
    t3_write_a: assert property (wr_t3 |=> timer3_reload_upper ==
        $past(sfr_wdata[`BIT_T3_HI:`BIT_T3_LO])) else $error("t3 write");
    source_inst_a: assert property (!mode[`BIT_SRC] && !to_wdt
        && !inst_clock_tick |=> !pre_out) else $error("stray tick");
    route_a: assert property (to_wdt && !watchdog_tick |=>
        !pre_out) else $error("prescaler route");
    edge_fall_a: assert property (mode[`BIT_EDGE] && mode[`BIT_SRC]
        && to_wdt && $fell(ext_src) |-> timer0_tick)
        else $error("falling edge missed");

    flag_cov: cover property (timer3_underflow ##1 wr_irq);
    edge_cov: cover property (mode[`BIT_SRC] && ext_edge);
    wdt_cov: cover property (to_wdt && pre_out);
    rate_cov: cover property (!to_wdt && mode[`RATE_HI:`RATE_LO] == 3'h7
        && pre_out);
    mask_cov: cover property (sfr_read && sfr_addr == `ADDR_IRQ2
        && ext_irq_two_flag && !ext_irq_two_enable);
endmodule

/* core/timer_prescaler_params.svh */
// Purpose: Constants for the timer and prescaler control block
// Assumes: Eight-bit special function register port
// Notes:   Included by the design modules and the bench
`ifndef TIMER_PRESCALER_PARAMS_SVH
`define TIMER_PRESCALER_PARAMS_SVH

`define ADDR_TIMER_UPPER    8'h19
`define ADDR_TIMER3_UPPER   8'h1C
`define ADDR_IRQ2           8'h1F

`define MODE_RESET          8'h3F
`define UPPER_RESET         8'h00
`define IRQ2_RESET          8'h00
`define PRESCALE_RESET      8'hFF

`define BIT_T2_HI           7
`define BIT_T2_LO           6
`define BIT_T1_HI           5
`define BIT_T1_LO           4
`define BIT_T3_HI           5
`define BIT_T3_LO           4
`define BIT_PWM2_HI         3
`define BIT_PWM2_LO         2
`define BIT_PWM1_HI         1
`define BIT_PWM1_LO         0
`define BIT_PWM3_HI         1
`define BIT_PWM3_LO         0

`define BIT_IRQ2_FLAG       7
`define BIT_T3_FLAG         4
`define BIT_IRQ2_EN         3
`define BIT_T3_EN           0

`define BIT_LOW_SUB         7
`define BIT_SPARE           6
`define BIT_SRC             5
`define BIT_EDGE            4
`define BIT_TO_WDT          3
`define RATE_HI             2
`define RATE_LO             0

`endif

/* core/timer_prescaler_pkg.sv */
// Purpose: Types shared by the timer and prescaler control block
// Assumes: Nothing beyond the parameter header
// Notes:   Holds types only
package timer_prescaler_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] rate_t;
    typedef logic [9:0] count_t;
endpackage
